/* dma_channel_transfer_control.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_channel_transfer_control (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic normal_mode_in,
    input wire logic nmi_in,
    input wire logic adc_end_in,
    input wire logic [1:0] serial_comm_unit_tx_in,
    input wire logic [1:0] serial_comm_unit_rx_in,
    input wire logic [5:0] pulse_timer_unit_in,
    input wire logic external_transfer_request_pin_in,
    input wire logic xfer_done_in,
    output logic xfer_req_a_out,
    output logic xfer_req_b_out,
    output logic [31:0] dest_address_b_out,
    output logic end_irq_a_out,
    output logic end_irq_b_out,
    output logic susp_irq_a_out,
    output logic susp_irq_b_out,
    output logic irq_out
);
    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] dest_address_reg_b;
        logic [15:0] count;
        logic [3:0] status;
        logic [3:0] mask;
        logic pin_prev;
        logic nmi_prev;
        logic req_a;
        logic req_b;
        logic end_a;
        logic end_b;
        logic susp_a;
        logic susp_b;
        logic irq;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic pin_sync_w;
    logic trig_a;
    logic trig_b;
    logic pin_fall;
    logic pin_low;

    pin_sync u_pin_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .async_in(external_transfer_request_pin_in),
        .sync_out(pin_sync_w)
    );

    assign pin_fall = state_reg.pin_prev & ~pin_sync_w;
    assign pin_low = ~pin_sync_w;

    trig_select u_sel_a (
        .code_in(state_reg.ctrl[dma_ctl_pkg::src_a_lsb +: 4]),
        .is_b_in(1'b0),
        .block_mode_in(state_reg.ctrl[dma_ctl_pkg::block_mode_bit]),
        .adc_in(adc_end_in),
        .pin_fall_in(pin_fall),
        .pin_low_in(pin_low),
        .ser_tx_in(serial_comm_unit_tx_in),
        .ser_rx_in(serial_comm_unit_rx_in),
        .tmr_in(pulse_timer_unit_in),
        .req_out(trig_a)
    );

    trig_select u_sel_b (
        .code_in(state_reg.ctrl[dma_ctl_pkg::src_b_lsb +: 4]),
        .is_b_in(1'b1),
        .block_mode_in(state_reg.ctrl[dma_ctl_pkg::block_mode_bit]),
        .adc_in(adc_end_in),
        .pin_fall_in(pin_fall),
        .pin_low_in(pin_low),
        .ser_tx_in(serial_comm_unit_tx_in),
        .ser_rx_in(serial_comm_unit_rx_in),
        .tmr_in(pulse_timer_unit_in),
        .req_out(trig_b)
    );

    function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            dma_ctl_pkg::ctrl_off: d = s.ctrl;
            dma_ctl_pkg::dest_off: d = s.dest_address_reg_b;
            dma_ctl_pkg::count_off: d = {16'h0000, s.count};
            dma_ctl_pkg::status_off: d = {28'h0000000, s.status};
            dma_ctl_pkg::mask_off: d = {28'h0000000, s.mask};
            dma_ctl_pkg::trig_off: d = {30'h0, s.req_b, s.req_a};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    logic ch_en_a;
    logic ch_en_b;
    logic master;
    logic nmi_rise;
    logic [3:0] events;
    logic [3:0] w1c;
    logic done_a;
    logic done_b;
    logic suspended;

    always_comb begin
        state_next = state_reg;
        master = state_reg.ctrl[dma_ctl_pkg::master_bit];
        ch_en_a = state_reg.ctrl[dma_ctl_pkg::en_a_bit] & master;
        ch_en_b = state_reg.ctrl[dma_ctl_pkg::en_b_bit] & master;
        suspended = state_reg.ctrl[dma_ctl_pkg::suspend_bit];
        nmi_rise = nmi_in & ~state_reg.nmi_prev;
        done_a = xfer_done_in & state_reg.req_a;
        done_b = xfer_done_in & state_reg.req_b;
        w1c = 4'h0;
        events = 4'h0;
        if (ce_in) begin
            state_next.pin_prev = pin_sync_w;
            state_next.nmi_prev = nmi_in;
            // bus address phase
            if (hready_in) begin
                state_next.ph_valid = hsel_in & htrans_in[1];
                state_next.ph_write = hwrite_in;
                state_next.ph_addr = haddr_in;
                if (hsel_in & htrans_in[1] & ~hwrite_in) begin
                    state_next.rdata = read_mux(state_reg, haddr_in);
                end
            end
            // request generation
            state_next.req_a = state_reg.req_a & ~done_a;
            state_next.req_b = state_reg.req_b & ~done_b;
            if (ch_en_a & trig_a & ~suspended) begin
                state_next.req_a = 1'b1;
            end
            if (ch_en_b & trig_b & ~suspended) begin
                state_next.req_b = 1'b1;
            end
            if (!ch_en_a) begin
                state_next.req_a = 1'b0;
            end
            if (!ch_en_b) begin
                state_next.req_b = 1'b0;
            end
            // destination address step
            if (done_b & state_reg.ctrl[dma_ctl_pkg::dir_bit]) begin
                if (state_reg.ctrl[dma_ctl_pkg::decr_bit]) begin
                    state_next.dest_address_reg_b = state_reg.dest_address_reg_b - 32'h0000_0001;
                end else begin
                    state_next.dest_address_reg_b = state_reg.dest_address_reg_b + 32'h0000_0001;
                end
            end
            if ((done_a | done_b) && state_reg.count != 16'h0000) begin
                state_next.count = state_reg.count - 16'h0001;
            end
            events[dma_ctl_pkg::st_end_a] = done_a && state_reg.count == 16'h0001;
            events[dma_ctl_pkg::st_end_b] = done_b && state_reg.count == 16'h0001;
            events[dma_ctl_pkg::st_susp_a] = suspended & trig_a & ch_en_a;
            events[dma_ctl_pkg::st_susp_b] = suspended & trig_b & ch_en_b;
            // register writes
            if (state_reg.ph_valid & state_reg.ph_write) begin
                case (state_reg.ph_addr)
                    dma_ctl_pkg::ctrl_off: state_next.ctrl = hwdata_in;
                    dma_ctl_pkg::dest_off: state_next.dest_address_reg_b = hwdata_in;
                    dma_ctl_pkg::count_off: state_next.count = hwdata_in[15:0];
                    dma_ctl_pkg::status_off: w1c = hwdata_in[3:0];
                    dma_ctl_pkg::mask_off: state_next.mask = hwdata_in[3:0];
                    default: w1c = 4'h0;
                endcase
            end
            if (normal_mode_in & nmi_rise) begin
                state_next.ctrl[dma_ctl_pkg::master_bit] = 1'b0;
            end
            state_next.status = (state_reg.status & ~w1c) | events;
            state_next.end_a = state_next.status[dma_ctl_pkg::st_end_a]
                & state_next.ctrl[dma_ctl_pkg::end_ie_a_bit];
            state_next.end_b = state_next.status[dma_ctl_pkg::st_end_b]
                & state_next.ctrl[dma_ctl_pkg::end_ie_b_bit];
            state_next.susp_a = state_next.status[dma_ctl_pkg::st_susp_a]
                & state_next.ctrl[dma_ctl_pkg::susp_ie_a_bit];
            state_next.susp_b = state_next.status[dma_ctl_pkg::st_susp_b]
                & state_next.ctrl[dma_ctl_pkg::susp_ie_b_bit];
            state_next.irq = |(state_next.status & state_next.mask);
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '0;
            state_reg.pin_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata_out = state_reg.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign xfer_req_a_out = state_reg.req_a;
    assign xfer_req_b_out = state_reg.req_b;
    assign dest_address_b_out = state_reg.dest_address_reg_b;
    assign end_irq_a_out = state_reg.end_a;
    assign end_irq_b_out = state_reg.end_b;
    assign susp_irq_a_out = state_reg.susp_a;
    assign susp_irq_b_out = state_reg.susp_b;
    assign irq_out = state_reg.irq;
endmodule
`default_nettype wire

/* dma_channel_transfer_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_channel_transfer_control_bench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic hsel_in = 1'b0;
    logic hwrite_in = 1'b0;
    logic nmi_in = 1'b0;
    logic xfer_done_in = 1'b0;
    logic pin_low = 1'b0;
    logic normal_mode_in = 1'b1;
    logic [7:0] haddr_in = 8'h00;
    logic [1:0] htrans_in = 2'h0;
    logic [31:0] hwdata_in = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] prev;
    logic [10:0] ev = 11'h000;
    wire logic [31:0] hrdata_out;
    wire logic [31:0] dest_address_b_out;
    wire logic hreadyout_out, hresp_out, xfer_req_a_out, xfer_req_b_out, irq_out;
    wire logic end_irq_a_out, end_irq_b_out, susp_irq_a_out, susp_irq_b_out;
    wire logic adc_end_in, external_transfer_request_pin_in;
    wire logic [1:0] serial_comm_unit_tx_in, serial_comm_unit_rx_in;
    wire logic [5:0] pulse_timer_unit_in;
    wire logic hready_in = hreadyout_out;
    int n_mismatch = 0;
    int n_compared = 0;
    dma_channel_transfer_control i_dut (.mclk_in, .reset_in, .ce_in(1'b1), .hsel_in, .haddr_in,
        .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in, .hrdata_out,
        .hreadyout_out, .hresp_out, .normal_mode_in, .nmi_in, .adc_end_in,
        .serial_comm_unit_tx_in, .serial_comm_unit_rx_in, .pulse_timer_unit_in,
        .external_transfer_request_pin_in, .xfer_done_in, .xfer_req_a_out, .xfer_req_b_out,
        .dest_address_b_out, .end_irq_a_out, .end_irq_b_out, .susp_irq_a_out, .susp_irq_b_out,
        .irq_out);
    dma_periph_model i_peer (.mclk_in, .ev_in(ev), .pin_low_in(pin_low), .adc_out(adc_end_in),
        .tx_out(serial_comm_unit_tx_in), .rx_out(serial_comm_unit_rx_in),
        .tmr_out(pulse_timer_unit_in), .pin_out(external_transfer_request_pin_in));
    always #50 mclk_in = ~mclk_in;
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic fire(input logic [10:0] e);
        ev <= e;
        cyc(1);
        ev <= 11'h000;
        cyc(4);
    endtask
    task automatic serve;
        xfer_done_in <= 1'b1;
        cyc(1);
        xfer_done_in <= 1'b0;
        cyc(1);
    endtask
    function automatic logic [10:0] ev_of(input logic [3:0] c);
        case (c)
            4'h1: return 11'h001;
            4'h4, 4'h5, 4'h6, 4'h7: return 11'h002 << (c - 4'h4);
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: return 11'h020 << (c - 4'h8);
            default: return 11'h7ff;
        endcase
    endfunction
    task automatic t_regs;
        bus(1'b0, dma_ctl_pkg::ctrl_off, 32'h0);
        chk(rd, dma_ctl_pkg::ctrl_reset);
        chk({30'h0, hreadyout_out, hresp_out}, 32'h0000_0002);
        bus(1'b1, 8'h1c, 32'hffff_ffff);
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0000_0000);
        bus(1'b1, dma_ctl_pkg::ctrl_off, 32'h0007_b0f8);
        bus(1'b0, dma_ctl_pkg::ctrl_off, 32'h0);
        chk(rd, 32'h0007_b0f8);
    endtask
    task automatic t_codes;
        for (int k = 0; k < 32; k++) begin
            logic [3:0] c;
            c = k[3:0];
            bus(1'b1, dma_ctl_pkg::ctrl_off, k[4] ? {12'h0, c, 16'h0006} : {16'h0, c, 12'h005});
            fire(ev_of(c));
            chb(k[4] ? xfer_req_b_out : xfer_req_a_out, !(c inside {0, 2, 3, 14, 15}));
            serve;
        end
    endtask
    task automatic t_pin;
        bus(1'b1, dma_ctl_pkg::ctrl_off, 32'h0002_0006);
        pin_low <= 1'b1;
        cyc(6);
        chb(xfer_req_b_out, 1'b1);
        serve;
        cyc(4);
        chb(xfer_req_b_out, 1'b0);
        pin_low <= 1'b0;
        cyc(4);
        bus(1'b1, dma_ctl_pkg::ctrl_off, 32'h0003_0006);
        pin_low <= 1'b1;
        cyc(6);
        serve;
        cyc(2);
        chb(xfer_req_b_out, 1'b1);
        pin_low <= 1'b0;
        cyc(4);
        serve;
        cyc(2);
        chb(xfer_req_b_out, 1'b0);
    endtask
    task automatic t_gate;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, dma_ctl_pkg::ctrl_off, k == 0 ? 32'h1001 : (k == 1 ? 32'h1004 : 32'h1005));
            fire(11'h001);
            chb(xfer_req_a_out, k == 2);
            bus(1'b0, dma_ctl_pkg::trig_off, 32'h0);
            chk(rd, {31'h0, k == 2});
            serve;
        end
        for (int k = 0; k < 2; k++) begin
            normal_mode_in <= k == 0;
            bus(1'b1, dma_ctl_pkg::ctrl_off, 32'h1005);
            nmi_in <= 1'b1;
            cyc(2);
            nmi_in <= 1'b0;
            fire(11'h001);
            chb(xfer_req_a_out, k == 1);
            bus(1'b0, dma_ctl_pkg::ctrl_off, 32'h0);
            chb(rd[2], k == 1);
            serve;
        end
        normal_mode_in <= 1'b1;
    endtask
    task automatic t_dest;
        logic [31:0] mode [4] = '{32'h0006_0006, 32'h0006_0106, 32'h0006_0086, 32'h0006_0186};
        bus(1'b1, dma_ctl_pkg::dest_off, 32'h0000_0100);
        bus(1'b0, dma_ctl_pkg::dest_off, 32'h0);
        chk(rd, 32'h0000_0100);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, dma_ctl_pkg::ctrl_off, mode[k]);
            cyc(1);
            prev = dest_address_b_out;
            fire(11'h008);
            serve;
            if (k < 2) chk(dest_address_b_out, prev);
            else chk(dest_address_b_out, k == 2 ? prev + 32'h1 : prev - 32'h1);
        end
    endtask
    task automatic t_irq;
        bus(1'b1, dma_ctl_pkg::mask_off, 32'h1);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, dma_ctl_pkg::count_off, 32'h1);
            bus(1'b1, dma_ctl_pkg::ctrl_off, k == 0 ? 32'h0001_101f : 32'h0001_1007);
            fire(11'h001);
            serve;
            cyc(2);
            chb(end_irq_a_out, k == 0);
            chb(end_irq_b_out, k == 0);
            chb(irq_out, 1'b1);
            bus(1'b0, dma_ctl_pkg::status_off, 32'h0);
            chk(rd, 32'h0000_0003);
            bus(1'b0, dma_ctl_pkg::count_off, 32'h0);
            chk(rd, 32'h0000_0000);
            bus(1'b1, dma_ctl_pkg::status_off, 32'hf);
            cyc(2);
            chb(irq_out, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, dma_ctl_pkg::ctrl_off, k == 0 ? 32'h0011_1067 : 32'h0011_1007);
            fire(11'h001);
            chb(susp_irq_a_out, k == 0);
            chb(susp_irq_b_out, k == 0);
            chb(xfer_req_a_out, 1'b0);
            chb(xfer_req_b_out, 1'b0);
            chb(irq_out, 1'b0);
            bus(1'b1, dma_ctl_pkg::status_off, 32'hf);
        end
    endtask
    initial begin
        cyc(12);
        reset_in <= 1'b0;
        cyc(1);
        t_regs;
        t_codes;
        t_pin;
        t_gate;
        t_dest;
        t_irq;
        end_sim;
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire

/* dma_ctl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_ctl_chk (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic normal_mode_in,
    input wire logic nmi_in,
    input wire logic adc_end_in,
    input wire logic [1:0] serial_comm_unit_tx_in,
    input wire logic external_transfer_request_pin_in,
    input wire logic xfer_done_in,
    input wire logic xfer_req_a_out,
    input wire logic xfer_req_b_out,
    input wire logic [31:0] dest_address_b_out,
    input wire logic end_irq_a_out,
    input wire logic susp_irq_a_out
);
    logic [31:0] ctrl_q;
    logic wr_q;
    logic dwr_q;
    logic nmi_q;
    wire logic take = hsel_in && htrans_in[1] && hready_in && hwrite_in;
    wire logic go_a = ctrl_q[0] && ctrl_q[2] && !ctrl_q[20];
    wire logic go_b = ctrl_q[1] && ctrl_q[2] && !ctrl_q[20];
    wire logic [3:0] sa = ctrl_q[15:12];
    wire logic [3:0] sb = ctrl_q[19:16];
    // shadow of the control word, master cleared on nmi
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= 32'h0000_0000;
            wr_q <= 1'b0;
            dwr_q <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            wr_q <= take && haddr_in == dma_ctl_pkg::ctrl_off;
            dwr_q <= take && haddr_in == dma_ctl_pkg::dest_off;
            nmi_q <= nmi_in;
            if (wr_q) begin
                ctrl_q <= hwdata_in;
            end
            if (nmi_in && !nmi_q && normal_mode_in) begin
                ctrl_q[2] <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    a_adc_start: assert property (go_a && sa == 4'h1 && adc_end_in && !xfer_done_in
        |=> xfer_req_a_out) else $error("adc event gave no request");
    a_ser1_tx: assert property (go_b && sb == 4'h6 && serial_comm_unit_tx_in[1]
        && !xfer_done_in |=> xfer_req_b_out) else $error("serial tx event gave no request");
    a_pin_low: assert property ((go_b && sb == 4'h3 && !external_transfer_request_pin_in
        && !xfer_done_in) [*4] |=> xfer_req_b_out) else $error("low pin gave no request");
    a_req_gate: assert property (($rose(xfer_req_a_out) |-> $past(go_a))
        and ($rose(xfer_req_b_out) |-> $past(go_b))) else $error("request while disabled");
    a_no_source: assert property ($rose(xfer_req_a_out)
        |-> !($past(sa) inside {4'h0, 4'h2, 4'h3, 4'he, 4'hf})) else $error("request from no source");
    a_dest_hold: assert property (xfer_done_in && !ctrl_q[7] && !dwr_q
        |=> $stable(dest_address_b_out)) else $error("fixed address moved");
    a_dest_step: assert property (xfer_done_in && xfer_req_b_out && !xfer_req_a_out
        && ctrl_q[7] && !dwr_q |=> ($past(ctrl_q[8]) ? $past(dest_address_b_out)
        - dest_address_b_out : dest_address_b_out - $past(dest_address_b_out)) == 32'h0000_0001)
        else $error("address stepped the wrong way");
    a_end_gate: assert property (end_irq_a_out |-> ctrl_q[3] || $past(ctrl_q[3]))
        else $error("end request while disabled");
    a_susp_gate: assert property (susp_irq_a_out |-> ctrl_q[5] || $past(ctrl_q[5]))
        else $error("suspend request while disabled");
endmodule
bind dma_channel_transfer_control dma_ctl_chk i_chk (.mclk_in, .reset_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .normal_mode_in, .nmi_in, .adc_end_in,
    .serial_comm_unit_tx_in, .external_transfer_request_pin_in, .xfer_done_in, .xfer_req_a_out,
    .xfer_req_b_out, .dest_address_b_out, .end_irq_a_out, .susp_irq_a_out);
`default_nettype wire

/* dma_ctl_pkg.sv */
// What this block does
// - destination address B holds when direction 0; else steps up (sel 0) or down.
// - sub-channel A code 0001 starts on converter end; code 0000 selects nothing.
// - sub-channel B code 0010 starts on each falling edge of request pin.
// - sub-channel B code 0011 requests while the request pin samples low.
// - code 0110 starts on serial unit 1 transmit-complete request.
// - code 0111 starts on serial unit 1 receive-complete request.
// - codes 1011/1100 start on timer 3/4 compare requests; 1110, 1111 select nothing.
// - in normal mode a non-maskable interrupt clears the master enable.
package dma_ctl_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] src_off = 8'h04;
    localparam logic [7:0] dest_off = 8'h08;
    localparam logic [7:0] count_off = 8'h0c;
    localparam logic [7:0] status_off = 8'h10;
    localparam logic [7:0] mask_off = 8'h14;
    localparam logic [7:0] trig_off = 8'h18;
    // ctrl fields
    localparam int en_a_bit = 0;
    localparam int en_b_bit = 1;
    localparam int master_bit = 2;
    localparam int end_ie_a_bit = 3;
    localparam int end_ie_b_bit = 4;
    localparam int susp_ie_a_bit = 5;
    localparam int susp_ie_b_bit = 6;
    localparam int dir_bit = 7;
    localparam int decr_bit = 8;
    localparam int block_mode_bit = 9;
    localparam int src_a_lsb = 12;
    localparam int src_b_lsb = 16;
    localparam int suspend_bit = 20;
    // status bits
    localparam int st_end_a = 0;
    localparam int st_end_b = 1;
    localparam int st_susp_a = 2;
    localparam int st_susp_b = 3;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [3:0] code_none = 4'h0;
    localparam logic [3:0] code_adc = 4'h1;
    localparam logic [3:0] code_pin_fall = 4'h2;
    localparam logic [3:0] code_pin_low = 4'h3;
    localparam logic [3:0] code_ser0_tx = 4'h4;
    localparam logic [3:0] code_ser0_rx = 4'h5;
    localparam logic [3:0] code_ser1_tx = 4'h6;
    localparam logic [3:0] code_ser1_rx = 4'h7;
    localparam logic [3:0] code_tmr0 = 4'h8;
    localparam logic [3:0] code_tmr5 = 4'hd;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam int tmr_count = 6;
    localparam int sync_stages = 2;
    typedef enum logic [1:0] {
        idle_st,
        xfer_st
    } xfer_state_t;
endpackage

/* dma_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_periph_model (
    input wire logic mclk_in,
    input wire logic [10:0] ev_in,
    input wire logic pin_low_in,
    output logic adc_out,
    output logic [1:0] tx_out,
    output logic [1:0] rx_out,
    output logic [5:0] tmr_out,
    output logic pin_out
);
    initial begin
        {tmr_out, rx_out[1], tx_out[1], rx_out[0], tx_out[0], adc_out} = 11'h000;
        pin_out = 1'b1;
    end
    // one-cycle event pulses; request pin pulled up when released
    always @(posedge mclk_in) begin
        {tmr_out, rx_out[1], tx_out[1], rx_out[0], tx_out[0], adc_out} <= ev_in;
        pin_out <= !pin_low_in;
    end
endmodule
`default_nettype wire

/* pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic [dma_ctl_pkg::sync_stages-1:0] ff;
    } sync_state_t;
    sync_state_t state_reg;
    sync_state_t state_next;
    always_comb begin
        state_next = state_reg;
        if (ce_in) begin
            state_next.ff = {state_reg.ff[0], async_in};
        end
    end
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '{ff: {dma_ctl_pkg::sync_stages{1'b1}}};
        end else begin
            state_reg <= state_next;
        end
    end
    assign sync_out = state_reg.ff[dma_ctl_pkg::sync_stages-1];
endmodule
`default_nettype wire

/* trig_select.sv */
`timescale 1ns/100ps
`default_nettype none
module trig_select (
    input wire logic [3:0] code_in,
    input wire logic is_b_in,
    input wire logic block_mode_in,
    input wire logic adc_in,
    input wire logic pin_fall_in,
    input wire logic pin_low_in,
    input wire logic [1:0] ser_tx_in,
    input wire logic [1:0] ser_rx_in,
    input wire logic [5:0] tmr_in,
    output logic req_out
);
    logic [3:0] tidx;
    always_comb begin
        tidx = code_in - dma_ctl_pkg::code_tmr0;
        req_out = 1'b0;
        case (code_in)
            dma_ctl_pkg::code_adc: req_out = adc_in;
            dma_ctl_pkg::code_pin_fall: req_out = is_b_in & pin_fall_in;
            dma_ctl_pkg::code_pin_low: req_out = is_b_in & pin_low_in;
            dma_ctl_pkg::code_ser0_tx: req_out = ser_tx_in[0];
            dma_ctl_pkg::code_ser0_rx: req_out = ser_rx_in[0];
            dma_ctl_pkg::code_ser1_tx: req_out = ser_tx_in[1];
            dma_ctl_pkg::code_ser1_rx: req_out = ser_rx_in[1];
            default: begin
                if (code_in >= dma_ctl_pkg::code_tmr0 && code_in <= dma_ctl_pkg::code_tmr5) begin
                    req_out = tmr_in[tidx[2:0]];
                end
            end
        endcase
        if (block_mode_in) begin
            req_out = req_out;
        end
    end
endmodule
`default_nettype wire
